/* File: shared/amc_pkg.sv */
// Constants and types for the converter control block
package amc_pkg;
  // Address field positions
  localparam int ADDR_W          = 4;
  localparam int BIT_POL         = 0;
  localparam int BIT_SEL         = 1;
  localparam int BIT_MODE_LO     = 2;
  localparam int BIT_MODE_HI     = 3;
  localparam int RES_W           = 8;
  localparam int NUM_CODES       = 256;
  localparam logic [3:0] ADDR_RST = 4'h0;
  localparam logic [7:0] RES_RST  = 8'h00;
  // Input selector codes
  localparam logic [2:0] SRC_AIN1 = 3'h0;
  localparam logic [2:0] SRC_AIN2 = 3'h1;
  localparam logic [2:0] SRC_AIN3 = 3'h2;
  localparam logic [2:0] SRC_AIN4 = 3'h3;
  localparam logic [2:0] SRC_GND  = 3'h4;
  // Timing
  localparam int CLK_PERIOD_NS   = 4;
  localparam int CONV_MAX_US     = 40;
  localparam int CONV_MAX_CYC    = (CONV_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int HALF_PER        = 2;
  localparam int STEP_PER        = 2 * HALF_PER;
  localparam logic [3:0] HALF_CNT = 4'(HALF_PER - 1);
  localparam logic [3:0] STEP_CNT = 4'(STEP_PER - 1);

  typedef enum logic [2:0]
  {
    AMC_IDLE   = 3'b000,
    AMC_SAMP_P = 3'b001,
    AMC_SAMP_N = 3'b010,
    AMC_SAR    = 3'b011,
    AMC_DONE   = 3'b100
  } amc_state_e;
endpackage : amc_pkg

/* File: core/amc_sar.sv */
// Successive approximation search on an 8-bit trial code
`timescale 1ns/1ns
`default_nettype none
module amc_sar
(
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic                   start,
  input  wire logic                   step,
  input  wire logic [amc_pkg::RES_W-1:0] samp_p,
  input  wire logic [amc_pkg::RES_W-1:0] samp_n,
  output logic                        busy,
  output logic [amc_pkg::RES_W-1:0]   code
);
  import amc_pkg::*;

  logic [RES_W-1:0] trial_bit;
  logic [RES_W-1:0] diff;
  logic             neg;
  logic [RES_W-1:0] next_code;

  // Difference clamps to zero when the negative input is higher
  assign neg       = samp_p < samp_n;
  assign diff      = neg ? RES_RST : samp_p - samp_n;
  assign next_code = ((code | trial_bit) <= diff) ? (code | trial_bit) : code;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      code      <= RES_RST;
      trial_bit <= RES_RST;
      busy      <= 1'b0;
    end
    else if (start)
    begin
      code      <= RES_RST;
      trial_bit <= 8'h80;
      busy      <= 1'b1;
    end
    else if (busy && step)
    begin
      code      <= next_code;
      trial_bit <= trial_bit >> 1;
      busy      <= (trial_bit != 8'h01);
    end
  end

  property p_sar_len;
    @(posedge clk) disable iff (!rstn) $rose(busy) |-> busy [*8];
  endproperty
  a_sar_len: assert property (p_sar_len) else $error("Search ended too early");
endmodule : amc_sar
`default_nettype wire

/* File: core/amc_ctrl.sv */
// Multiplexer select and conversion control of the converter
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Convert selected positive minus negative input by an 8-bit binary search.
// - Positive below negative returns code zero.
// - Pairing mode comes only from the written address.
// - Bit2 low: differential; bit1 picks pair, bit0 swaps polarity.
// - Bits 3:2 = 01: single-ended, channel by bits 1:0 against ground.
// - Bits 3:2 = 11: channels one to three against channel four.
// - Result spans 256 codes, step is reference over 256.
// - Sample positive input, then negative half a clock period later.
// - Write strobe falling with select low clears done and arms.
// - Write rising with read high latches address and starts conversion.
// - Read held low across write keeps config and outputs old result.
// - Within 40 us result latched and done low; read clears it.
module amc_ctrl
(
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire logic                      cs_n,
  input  wire logic                      wr_n,
  input  wire logic                      rd_n,
  input  wire logic [amc_pkg::RES_W-1:0] result_bus_in,
  output logic [amc_pkg::RES_W-1:0]      result_bus_out,
  output logic                           result_bus_oe_n,
  input  wire logic [amc_pkg::RES_W-1:0] ain_1,
  input  wire logic [amc_pkg::RES_W-1:0] ain_2,
  input  wire logic [amc_pkg::RES_W-1:0] ain_3,
  input  wire logic [amc_pkg::RES_W-1:0] ain_4,
  output logic                           conv_done_n,
  output logic [amc_pkg::ADDR_W-1:0]     mux_addr,
  output logic                           conv_busy
);
  import amc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [2:0] ctl_s1;
  logic [2:0] ctl_s2;
  logic [2:0] ctl_q;
  logic [ADDR_W-1:0] dat_s1;
  logic [ADDR_W-1:0] dat_s2;
  logic [RES_W-1:0]  ain_s1 [4];
  logic [RES_W-1:0]  ain_s2 [4];
  logic [RES_W-1:0]  ain_in [4];

  assign ain_in[0] = ain_1;
  assign ain_in[1] = ain_2;
  assign ain_in[2] = ain_3;
  assign ain_in[3] = ain_4;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctl_s1 <= 3'h7;
      ctl_s2 <= 3'h7;
      ctl_q  <= 3'h7;
      dat_s1 <= ADDR_RST;
      dat_s2 <= ADDR_RST;
    end
    else
    begin
      ctl_s1 <= {cs_n, wr_n, rd_n};
      ctl_s2 <= ctl_s1;
      ctl_q  <= ctl_s2;
      dat_s1 <= result_bus_in[ADDR_W-1:0];
      dat_s2 <= dat_s1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_ain_sync
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
        begin
          ain_s1[gi] <= RES_RST;
          ain_s2[gi] <= RES_RST;
        end
        else
        begin
          ain_s1[gi] <= ain_in[gi];
          ain_s2[gi] <= ain_s1[gi];
        end
      end
    end
  endgenerate

  // ************************************************************
  // Strobe decode
  // ************************************************************
  logic cs_l;
  logic wr_l;
  logic rd_l;
  logic wr_fall;
  logic wr_rise;
  logic rd_fall;
  logic rd_all_low;
  logic start_ok;
  logic read_act;

  assign cs_l    = ~ctl_s2[2];
  assign wr_l    = ~ctl_s2[1];
  assign rd_l    = ~ctl_s2[0];
  assign wr_fall = wr_l & ctl_q[1] & cs_l;
  assign wr_rise = ~wr_l & ~ctl_q[1] & cs_l;
  assign rd_fall = rd_l & ctl_q[0] & cs_l;
  assign read_act = cs_l & rd_l;
  // Start on write rise with read high, unless read was low for the whole write-low time
  assign start_ok = wr_rise & ~rd_l & ~rd_all_low;

  // ************************************************************
  // Input selection
  // ************************************************************
  function automatic logic [5:0] sel_pair(input logic [ADDR_W-1:0] a);
    logic [2:0] p;
    logic [2:0] n;
    p = SRC_AIN1;
    n = SRC_GND;
    if (!a[BIT_MODE_LO])
    begin
      // Differential pairs
      p = {1'b0, a[BIT_SEL], a[BIT_POL]};
      n = {1'b0, a[BIT_SEL], ~a[BIT_POL]};
    end
    else if (!a[BIT_MODE_HI])
    begin
      // Single-ended against ground
      p = {1'b0, a[BIT_SEL], a[BIT_POL]};
      n = SRC_GND;
    end
    else
    begin
      // Pseudo-differential against channel four; code 1111 undefined
      p = {1'b0, a[BIT_SEL], a[BIT_POL]};
      n = SRC_AIN4;
    end
    return {p, n};
  endfunction : sel_pair

  function automatic logic [RES_W-1:0] pick(input logic [2:0] s,
                                            input logic [RES_W-1:0] v0,
                                            input logic [RES_W-1:0] v1,
                                            input logic [RES_W-1:0] v2,
                                            input logic [RES_W-1:0] v3);
    logic [RES_W-1:0] r;
    r = RES_RST;
    case (s)
      SRC_AIN1: r = v0;
      SRC_AIN2: r = v1;
      SRC_AIN3: r = v2;
      SRC_AIN4: r = v3;
      default:  r = RES_RST;
    endcase
    return r;
  endfunction : pick

  logic [5:0]       pair;
  logic [RES_W-1:0] pos_val;
  logic [RES_W-1:0] neg_val;

  assign pair    = sel_pair(mux_addr);
  assign pos_val = pick(pair[5:3], ain_s2[0], ain_s2[1], ain_s2[2], ain_s2[3]);
  assign neg_val = pick(pair[2:0], ain_s2[0], ain_s2[1], ain_s2[2], ain_s2[3]);

  // ************************************************************
  // Conversion sequencer
  // ************************************************************
  amc_state_e       state;
  amc_state_e       next_state;
  logic [3:0]       tick;
  logic [RES_W-1:0] samp_p;
  logic [RES_W-1:0] samp_n;
  logic [RES_W-1:0] result;
  logic [RES_W-1:0] sar_code;
  logic             sar_busy;
  logic             sar_start;
  logic             sar_step;
  logic             tick_end;

  assign tick_end  = (tick == ((state == AMC_SAR) ? STEP_CNT : HALF_CNT));
  assign sar_start = (state == AMC_SAMP_N) & tick_end;
  assign sar_step  = (state == AMC_SAR) & tick_end;

  always_comb
  begin
    next_state = state;
    case (state)
      AMC_IDLE:   if (start_ok) next_state = AMC_SAMP_P;
      AMC_SAMP_P: if (tick_end) next_state = AMC_SAMP_N;
      AMC_SAMP_N: if (tick_end) next_state = AMC_SAR;
      AMC_SAR:    if (!sar_busy && tick == 4'h0 && !sar_start) next_state = AMC_DONE;
      AMC_DONE:   next_state = AMC_IDLE;
      default:    next_state = AMC_IDLE;
    endcase
    if (start_ok && state != AMC_IDLE) next_state = AMC_SAMP_P;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state      <= AMC_IDLE;
      tick       <= 4'h0;
      samp_p     <= RES_RST;
      samp_n     <= RES_RST;
      result     <= RES_RST;
      mux_addr   <= ADDR_RST;
      rd_all_low <= 1'b0;
      conv_done_n <= 1'b1;
      conv_busy  <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      tick      <= (tick_end || state != next_state) ? 4'h0 : tick + 4'h1;
      conv_busy <= (next_state != AMC_IDLE);
      if (wr_fall) rd_all_low <= rd_l;
      else if (wr_l && !rd_l) rd_all_low <= 1'b0;
      if (start_ok) mux_addr <= dat_s2;
      if (state == AMC_SAMP_P && tick_end) samp_p <= pos_val;
      if (state == AMC_SAMP_N && tick_end) samp_n <= neg_val;
      if (state == AMC_DONE) result <= sar_code;
      if (state == AMC_DONE) conv_done_n <= 1'b0;
      else if (wr_fall || rd_fall) conv_done_n <= 1'b1;
    end
  end

  amc_sar amc_sar_inst
  (
    .clk    (clk),
    .rstn   (rstn),
    .start  (sar_start),
    .step   (sar_step),
    .samp_p (samp_p),
    .samp_n (samp_n),
    .busy   (sar_busy),
    .code   (sar_code)
  );

  // ************************************************************
  // Data bus drive
  // ************************************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      result_bus_out  <= RES_RST;
      result_bus_oe_n <= 1'b1;
    end
    else
    begin
      result_bus_out  <= result;
      result_bus_oe_n <= ~read_act;
    end
  end

  property p_done_time;
    $rose(conv_busy) |-> ##[1:80] ($fell(conv_done_n) || $rose(conv_busy));
  endproperty
  a_done_time: assert property (p_done_time) else $error("Done flag not set in time");
  property p_wr_clear;
    wr_fall && state != AMC_DONE |=> conv_done_n;
  endproperty
  a_wr_clear: assert property (p_wr_clear) else $error("Write did not clear done");
  property p_rd_clear;
    rd_fall && state != AMC_DONE |=> conv_done_n;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("Read did not clear done");
  property p_addr_hold;
    !start_ok |=> $stable(mux_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("Stray address change");
  property p_zero;
    state == AMC_DONE && samp_p < samp_n |-> sar_code == RES_RST;
  endproperty
  a_zero: assert property (p_zero) else $error("Negative input not clamped");
  property p_exact;
    state == AMC_DONE && samp_p >= samp_n |-> sar_code == samp_p - samp_n;
  endproperty
  a_exact: assert property (p_exact) else $error("Search result wrong");
  property p_order;
    state == AMC_SAMP_P && tick_end && !start_ok |=> state == AMC_SAMP_N ##2 state == AMC_SAR;
  endproperty
  a_order: assert property (p_order) else $error("Sampling order wrong");
  property p_oe;
    !read_act |=> result_bus_oe_n;
  endproperty
  a_oe: assert property (p_oe) else $error("Bus driven outside read");
endmodule : amc_ctrl
`default_nettype wire

/* File: tb/amc_host.sv */
// Bus host model driving the converter strobes and data pins
`timescale 1ns/1ns
`default_nettype none
module amc_host
(
  input  wire logic       clk,
  input  wire logic [7:0] pins,
  input  wire logic       done_n,
  output logic            cs_n,
  output logic            wr_n,
  output logic            rd_n,
  output logic            drv,
  output logic [7:0]      dq
);
  // ****
  // Idle levels
  // ****
  initial
  begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    drv  = 1'b0;
    dq   = 8'h5A;
  end
  // ****
  // Write cycle, read strobe optionally held low throughout
  // ****
  task automatic wr(input logic [3:0] a, input logic rdl, output logic [7:0] seen,
                    output logic dn);
    @(negedge clk);
    cs_n = 1'b0;
    rd_n = ~rdl;
    drv  = ~rdl;
    dq   = {4'h0, a};
    wr_n = 1'b0;
    repeat (5) @(negedge clk);
    seen = pins;
    dn   = done_n;
    wr_n = 1'b1;
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    rd_n = 1'b1;
    drv  = 1'b0;
    dq   = ~dq;
    repeat (3) @(negedge clk);
  endtask : wr
  // ****
  // Read cycle
  // ****
  task automatic rd(output logic [7:0] v);
    @(negedge clk);
    cs_n = 1'b0;
    rd_n = 1'b0;
    repeat (5) @(negedge clk);
    v    = pins;
    rd_n = 1'b1;
    cs_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask : rd
endmodule : amc_host
`default_nettype wire

/* File: tb/amc_ctrl_tb.sv */
// Testbench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module amc_ctrl_tb;
  import amc_pkg::*;
  logic       clk;
  logic       rstn;
  logic       cs_n;
  logic       wr_n;
  logic       rd_n;
  logic       drv;
  logic       dn;
  logic       done_n;
  logic       oe_n;
  logic       busy;
  logic       bsy;
  logic [3:0] mux_addr;
  logic [7:0] dq;
  logic [7:0] bus_out;
  logic [7:0] pins;
  logic [7:0] seen;
  logic [7:0] v;
  logic [7:0] a1 = 8'hFF;
  logic [7:0] a2 = 8'h30;
  logic [7:0] a3 = 8'hA0;
  logic [7:0] a4 = 8'h20;
  int         err_total = 0;
  int         check_count = 0;
  assign pins = oe_n ? dq : bus_out;
  amc_ctrl amc_ctrl_inst
  (
    .clk             (clk),
    .rstn            (rstn),
    .cs_n            (cs_n),
    .wr_n            (wr_n),
    .rd_n            (rd_n),
    .result_bus_in   (pins),
    .result_bus_out  (bus_out),
    .result_bus_oe_n (oe_n),
    .ain_1           (a1),
    .ain_2           (a2),
    .ain_3           (a3),
    .ain_4           (a4),
    .conv_done_n     (done_n),
    .mux_addr        (mux_addr),
    .conv_busy       (busy)
  );
  amc_host amc_host_inst
  (
    .clk    (clk),
    .pins   (pins),
    .done_n (done_n),
    .cs_n   (cs_n),
    .wr_n   (wr_n),
    .rd_n   (rd_n),
    .drv    (drv),
    .dq     (dq)
  );
  always @(negedge clk)
  begin
    if (drv && !oe_n)
    begin
      $display("Error result_bus_oe_n expected 1 seen 0");
      err_total++;
    end
  end
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ****
  // Helpers
  // ****
  function automatic logic [7:0] expv(input logic [3:0] a);
    logic [7:0] ch [4];
    logic [7:0] p;
    logic [7:0] n;
    ch = '{a1, a2, a3, a4};
    p = ch[a[1:0]];
    n = a[3] ? a4 : 8'h00;
    if (!a[2]) n = ch[{a[1], ~a[0]}];
    return (p > n) ? 8'(p - n) : 8'h00;
  endfunction : expv
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : chk
  task automatic give_verdict();
    $display("Checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task automatic wait_done();
    int i;
    i = 0;
    bsy = 1'b0;
    while (done_n !== 1'b0 && i < CONV_MAX_CYC)
    begin
      @(negedge clk);
      bsy = bsy | busy;
      i++;
    end
    if (i >= CONV_MAX_CYC)
    begin
      $display("Error conv_done_n expected 0 seen 1");
      err_total++;
      give_verdict();
    end
  endtask : wait_done
  // ****
  // Main sequence
  // ****
  initial
  begin
    rstn = 1'b0;
    repeat (5) @(negedge clk);
    chk("conv_done_n", 8'h01, done_n);
    chk("result_bus_oe_n", 8'h01, oe_n);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    for (int a = 0; a < 15; a++)
    begin
      amc_host_inst.wr(4'(a), 1'b0, seen, dn);
      wait_done();
      chk("conv_busy", 8'h01, bsy);
      chk("mux_addr", 8'(a), mux_addr);
      amc_host_inst.rd(v);
      chk("result_bus", expv(4'(a)), v);
      chk("conv_done_n", 8'h01, done_n);
      chk("result_bus_oe_n", 8'h01, oe_n);
    end
    amc_host_inst.wr(4'h4, 1'b0, seen, dn);
    wait_done();
    amc_host_inst.wr(4'h6, 1'b0, seen, dn);
    chk("conv_done_n", 8'h01, dn);
    wait_done();
    amc_host_inst.wr(4'h9, 1'b1, seen, dn);
    chk("result_bus", expv(4'h6), seen);
    repeat (10) @(negedge clk);
    chk("mux_addr", 8'h06, mux_addr);
    chk("conv_busy", 8'h00, busy);
    amc_host_inst.wr(4'h1, 1'b0, seen, dn);
    amc_host_inst.wr(4'hE, 1'b0, seen, dn);
    wait_done();
    amc_host_inst.rd(v);
    chk("result_bus", expv(4'hE), v);
    give_verdict();
  end
endmodule : amc_ctrl_tb
`default_nettype wire
